// ==== design/asscu_device.sv ====
// sensor end: spi frame capture on the link clock, command execution on core_clk
`timescale 1ns/10ps
module asscu_device #(
  parameter int BUSY_CYCLES = asscu_pkg::STORE_BUSY_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] angle,
  output logic             frameParityFault,
  output logic             commandSpacingFault,
  asscu_link_if.dev        link
);
  localparam int CNT_W = $clog2(BUSY_CYCLES + 1);
  localparam logic [CNT_W-1:0] BUSY_LOAD = CNT_W'(BUSY_CYCLES - 1);

  // ---------------- link clock domain ----------------
  logic                  frameRst;
  asscu_pkg::asscu_bit_t bitCnt;
  logic [15:0]           rxShift;
  logic [15:0]           txShift;
  logic [15:0]           cmdWord;
  logic                  reqToggle;
  logic                  misoBit;

  // written only in the core domain; read by the link at the first edge of a frame
  logic [15:0]           respWord;

  // chip select high ends the frame, so a short frame never completes
  assign frameRst = sys_rst | link.csN;

  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      bitCnt <= asscu_pkg::FRAME_FIRST;
    end else begin
      bitCnt <= bitCnt + 4'h1;
    end
  end

  always_ff @(posedge link.sclk or posedge sys_rst) begin
    if (sys_rst) begin
      rxShift <= 16'h0000;
    end else begin
      rxShift <= {rxShift[14:0], link.mosi};
    end
  end

  // sixteenth edge hands the whole frame over and flips the request toggle
  always_ff @(posedge link.sclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdWord   <= 16'h0000;
      reqToggle <= 1'b0;
    end else if (bitCnt == asscu_pkg::FRAME_LAST) begin
      cmdWord   <= {rxShift[14:0], link.mosi};
      reqToggle <= ~reqToggle;
    end
  end

  // answer goes out msb first, one bit per rising edge
  always_ff @(posedge link.sclk or posedge sys_rst) begin
    if (sys_rst) begin
      misoBit <= 1'b0;
      txShift <= 16'h0000;
    end else if (bitCnt == asscu_pkg::FRAME_FIRST) begin
      {misoBit, txShift} <= {respWord, 1'b0};
    end else begin
      {misoBit, txShift} <= {txShift, 1'b0};
    end
  end

  assign link.miso = misoBit;

  // ---------------- core clock domain ----------------
  logic                   reqSync;
  logic                   reqSeen;
  logic                   cmdStrobe;
  asscu_pkg::asscu_cmd_t  code;
  asscu_pkg::asscu_addr_t addr;
  asscu_pkg::asscu_val_t  value;
  logic                   isStoreCmd;
  logic                   accept;
  logic                   spacingHit;
  logic                   parityHit;
  logic                   clearErr;
  logic                   writeHit;

  asscu_sync #(
    .WIDTH (1)
  ) u_reqSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      (reqToggle),
    .dout     (reqSync)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqSeen <= 1'b0;
    end else begin
      reqSeen <= reqSync;
    end
  end

  // cmdWord is stable here: it next changes sixteen link clocks later
  assign cmdStrobe = reqSync ^ reqSeen;
  assign code      = cmdWord[asscu_pkg::CMD_MSB:asscu_pkg::CMD_LSB];
  assign addr      = cmdWord[asscu_pkg::ADDR_MSB:asscu_pkg::ADDR_LSB];
  assign value     = cmdWord[asscu_pkg::VAL_MSB:0];

  assign isStoreCmd = (code == asscu_pkg::CMD_STORE_ONE) ||
                      (code == asscu_pkg::CMD_STORE_ALL) ||
                      (code == asscu_pkg::CMD_RESTORE);

  logic storeBusy;

  assign accept     = cmdStrobe && isStoreCmd && !storeBusy;
  assign spacingHit = cmdStrobe && isStoreCmd && storeBusy;
  assign parityHit  = cmdStrobe && (code == asscu_pkg::CMD_UNUSED);
  assign clearErr   = cmdStrobe && (code == asscu_pkg::CMD_CLEAR_ERR);
  assign writeHit   = cmdStrobe && (code == asscu_pkg::CMD_WRITE_REG) &&
                      (addr != asscu_pkg::STATUS_ADDR);

  // store engine: starts busy with a restore so start-up reloads the registers
  asscu_pkg::asscu_cmd_t  persistOp;
  asscu_pkg::asscu_addr_t persistAddr;
  logic [CNT_W-1:0]       busyCnt;
  logic                   opDone;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      storeBusy   <= 1'b1;
      persistOp   <= asscu_pkg::CMD_RESTORE;
      persistAddr <= 5'h00;
      busyCnt     <= BUSY_LOAD;
    end else if (storeBusy) begin
      if (busyCnt == '0) begin
        storeBusy <= 1'b0;
      end else begin
        busyCnt <= busyCnt - 1'b1;
      end
    end else if (accept) begin
      storeBusy   <= 1'b1;
      persistOp   <= code;
      persistAddr <= addr;
      busyCnt     <= BUSY_LOAD;
    end
  end

  assign opDone = storeBusy && (busyCnt == '0);
  assign link.storeBusyOut = storeBusy;

  // working registers and the nonvolatile store, one entry per address
  asscu_pkg::asscu_val_t regs    [asscu_pkg::REG_COUNT];
  asscu_pkg::asscu_val_t persist [asscu_pkg::REG_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < asscu_pkg::REG_COUNT; gi++) begin : g_entry
      localparam asscu_pkg::asscu_addr_t IDX = asscu_pkg::asscu_addr_t'(gi);

      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          persist[gi] <= asscu_pkg::FACTORY[gi];
        end else if (opDone && (persistOp == asscu_pkg::CMD_STORE_ALL)) begin
          persist[gi] <= regs[gi];
        end else if (opDone && (persistOp == asscu_pkg::CMD_STORE_ONE) &&
                     (persistAddr == IDX)) begin
          persist[gi] <= regs[gi];
        end
      end

      // a restore finishing in the same cycle as a write overrides the write
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          regs[gi] <= 8'h00;
        end else if (opDone && (persistOp == asscu_pkg::CMD_RESTORE)) begin
          regs[gi] <= persist[gi];
        end else if (writeHit && (addr == IDX)) begin
          regs[gi] <= value;
        end
      end
    end
  endgenerate

  // error flags: a new event wins over a clear in the same cycle
  logic next_parity;
  logic next_spacing;
  logic errPin;

  assign next_parity  = parityHit  | (frameParityFault    & ~clearErr);
  assign next_spacing = spacingHit | (commandSpacingFault & ~clearErr);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frameParityFault    <= 1'b0;
      commandSpacingFault <= 1'b0;
      errPin              <= 1'b0;
    end else begin
      frameParityFault    <= next_parity;
      commandSpacingFault <= next_spacing;
      errPin              <= next_parity | next_spacing;
    end
  end

  assign link.errOut = errPin;

  // readback: the status address shows the error flags
  asscu_pkg::asscu_val_t statusByte;
  asscu_pkg::asscu_val_t readVal;

  always_comb begin
    statusByte = 8'h00;
    statusByte[asscu_pkg::ERR_PAR_BIT]     = frameParityFault;
    statusByte[asscu_pkg::ERR_SPACING_BIT] = commandSpacingFault;
  end

  always_comb begin
    if (addr == asscu_pkg::STATUS_ADDR) begin
      readVal = statusByte;
    end else begin
      readVal = regs[addr];
    end
  end

  // answer word for the next frame
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      respWord <= 16'h0000;
    end else if (cmdStrobe) begin
      case (code)
        asscu_pkg::CMD_READ_REG: begin
          respWord <= {angle[15:asscu_pkg::ANGLE_HI], readVal};
        end
        asscu_pkg::CMD_WRITE_REG: begin
          if (addr == asscu_pkg::STATUS_ADDR) begin
            respWord <= {angle[15:asscu_pkg::ANGLE_HI], statusByte};
          end else begin
            respWord <= {angle[15:asscu_pkg::ANGLE_HI], value};
          end
        end
        default: begin
          respWord <= angle;
        end
      endcase
    end
  end

endmodule // asscu_device

// ==== design/asscu_pkg.sv ====
// shared constants and types for the angle sensor spi command unit
// What this block does
// - write frame: code 100, address, value
// - write answer: angle high byte, new value, or status byte at the status address
// - host compares write acknowledge with intended value
// - start-up reloads registers from nonvolatile store
// - store or restore while busy is dropped
// - busy output high during store operations
// - host waits for busy low first before store or restore commands
// - code 111 stores one register, answers angle
// - code 110 stores all registers, answers angle
// - code 101 restores all registers, answers angle
// - code 001 clears error pin and flags
// - bits 15:13 decode; 000 reads angle
// - code 010 answers angle byte, register value
// - store command while busy flags spacing fault
// - code 011 flags parity fault
package asscu_pkg;

  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_MSB    = 15;
  localparam int CMD_LSB    = 13;
  localparam int ADDR_MSB   = 12;
  localparam int ADDR_LSB   = 8;
  localparam int VAL_MSB    = 7;
  localparam int ADDR_W     = 5;
  localparam int VAL_W      = 8;
  localparam int REG_COUNT  = 32;
  localparam int ANGLE_HI   = 8;

  typedef logic [2:0]        asscu_cmd_t;
  typedef logic [ADDR_W-1:0] asscu_addr_t;
  typedef logic [VAL_W-1:0]  asscu_val_t;
  typedef logic [3:0]        asscu_bit_t;

  localparam asscu_bit_t FRAME_FIRST = 4'h0;
  localparam asscu_bit_t FRAME_LAST  = 4'hf;

  // command codes
  localparam asscu_cmd_t CMD_READ_ANGLE = 3'h0;
  localparam asscu_cmd_t CMD_CLEAR_ERR  = 3'h1;
  localparam asscu_cmd_t CMD_READ_REG   = 3'h2;
  localparam asscu_cmd_t CMD_UNUSED     = 3'h3;
  localparam asscu_cmd_t CMD_WRITE_REG  = 3'h4;
  localparam asscu_cmd_t CMD_RESTORE    = 3'h5;
  localparam asscu_cmd_t CMD_STORE_ALL  = 3'h6;
  localparam asscu_cmd_t CMD_STORE_ONE  = 3'h7;

  // status register and its flag positions
  localparam asscu_addr_t STATUS_ADDR     = 5'h1a;
  localparam int          ERR_PAR_BIT     = 3;
  localparam int          ERR_SPACING_BIT = 2;

  // factory content of the nonvolatile store
  localparam asscu_val_t FACTORY [REG_COUNT] = '{
    4: 8'h6e, 7: 8'h87, 11: 8'he0, 14: 8'h90, 22: 8'h01, default: 8'h00
  };

  // timing
  localparam int CORE_PERIOD_NS    = 4;
  localparam int SCLK_PERIOD_NS    = 80;
  localparam int SCLK_HALF_CYCLES  = SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
  localparam int FRAME_GAP_NS      = 200;
  localparam int FRAME_GAP_CYCLES  = (FRAME_GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int STORE_BUSY_CYCLES = 1000;
  localparam int HOST_CNT_W        = 8;

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_WAIT  = 4'b0010,
    H_SHIFT = 4'b0100,
    H_GAP   = 4'b1000
  } asscu_hstate_e;

endpackage

// ==== design/asscu_link_if.sv ====
// spi link between the sensor command unit and its host
`timescale 1ns/10ps
interface asscu_link_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic storeBusyOut;
  logic errOut;

  modport dev (
    input  sclk,
    input  csN,
    input  mosi,
    output miso,
    output storeBusyOut,
    output errOut
  );

  modport host (
    output sclk,
    output csN,
    output mosi,
    input  miso,
    input  storeBusyOut,
    input  errOut
  );
endinterface // asscu_link_if

// ==== design/asscu_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/10ps
module asscu_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // asscu_sync

// ==== design/asscu_host.sv ====
// host end: issues two-frame operations and drives the link clock from core_clk
`timescale 1ns/10ps
module asscu_host (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        cmdValid,
  input  wire logic [2:0]  cmdCode,
  input  wire logic [4:0]  cmdAddr,
  input  wire logic [7:0]  cmdValue,
  output logic             cmdReady,
  output logic             respValid,
  output logic [15:0]      respWord,
  output logic             ackMismatch,
  output logic             errSeen,
  asscu_link_if.host       link
);
  localparam int W = asscu_pkg::HOST_CNT_W;
  localparam logic [W-1:0] HALF_END = W'(asscu_pkg::SCLK_HALF_CYCLES - 1);
  localparam logic [W-1:0] GAP_END  = W'(asscu_pkg::FRAME_GAP_CYCLES - 1);

  asscu_pkg::asscu_hstate_e state;
  logic [2:0]               pinSync;
  logic [W-1:0]             divCnt;
  asscu_pkg::asscu_bit_t    bitCnt;
  logic                     secondFrame;
  logic                     isStore;
  logic                     isWrite;
  logic [7:0]               wantValue;
  logic [15:0]              pendWord;
  logic [15:0]              txShift;
  logic [15:0]              rxShift;
  logic                     sclkReg;
  logic                     csNReg;
  logic                     mosiReg;

  asscu_sync #(
    .WIDTH (3)
  ) u_pinSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      ({link.errOut, link.storeBusyOut, link.miso}),
    .dout     (pinSync)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      errSeen <= 1'b0;
    end else begin
      errSeen <= pinSync[2];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= asscu_pkg::H_IDLE;
      cmdReady    <= 1'b1;
      respValid   <= 1'b0;
      respWord    <= 16'h0000;
      ackMismatch <= 1'b0;
      divCnt      <= '0;
      bitCnt      <= asscu_pkg::FRAME_FIRST;
      secondFrame <= 1'b0;
      isStore     <= 1'b0;
      isWrite     <= 1'b0;
      wantValue   <= 8'h00;
      pendWord    <= 16'h0000;
      txShift     <= 16'h0000;
      rxShift     <= 16'h0000;
      sclkReg     <= 1'b0;
      csNReg      <= 1'b1;
      mosiReg     <= 1'b0;
    end else begin
      respValid <= 1'b0;
      case (state)
        asscu_pkg::H_IDLE: begin
          if (cmdValid) begin
            cmdReady  <= 1'b0;
            pendWord  <= {cmdCode, cmdAddr, cmdValue};
            wantValue <= cmdValue;
            isWrite   <= (cmdCode == asscu_pkg::CMD_WRITE_REG);
            isStore   <= (cmdCode == asscu_pkg::CMD_STORE_ONE) ||
                         (cmdCode == asscu_pkg::CMD_STORE_ALL) ||
                         (cmdCode == asscu_pkg::CMD_RESTORE);
            state     <= asscu_pkg::H_WAIT;
          end
        end
        asscu_pkg::H_WAIT: begin
          if (!isStore || !pinSync[1]) begin
            csNReg      <= 1'b0;
            mosiReg     <= pendWord[15];
            txShift     <= pendWord;
            divCnt      <= '0;
            bitCnt      <= asscu_pkg::FRAME_FIRST;
            secondFrame <= 1'b0;
            state       <= asscu_pkg::H_SHIFT;
          end
        end
        asscu_pkg::H_SHIFT: begin
          if (divCnt != HALF_END) begin
            divCnt <= divCnt + 1'b1;
          end else begin
            divCnt <= '0;
            if (!sclkReg) begin
              sclkReg <= 1'b1;
            end else begin
              sclkReg <= 1'b0;
              rxShift <= {rxShift[14:0], pinSync[0]};
              txShift <= {txShift[14:0], 1'b0};
              mosiReg <= txShift[14];
              bitCnt  <= bitCnt + 4'h1;
              if (bitCnt == asscu_pkg::FRAME_LAST) begin
                csNReg <= 1'b1;
                state  <= asscu_pkg::H_GAP;
              end
            end
          end
        end
        asscu_pkg::H_GAP: begin
          if (divCnt != GAP_END) begin
            divCnt <= divCnt + 1'b1;
          end else if (!secondFrame) begin
            divCnt      <= '0;
            secondFrame <= 1'b1;
            csNReg      <= 1'b0;
            mosiReg     <= 1'b0;
            txShift     <= 16'h0000;
            state       <= asscu_pkg::H_SHIFT;
          end else begin
            respWord    <= rxShift;
            respValid   <= 1'b1;
            ackMismatch <= isWrite && (rxShift[7:0] != wantValue);
            cmdReady    <= 1'b1;
            state       <= asscu_pkg::H_IDLE;
          end
        end
        default: begin
          state <= asscu_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclkReg;
  assign link.csN  = csNReg;
  assign link.mosi = mosiReg;

endmodule // asscu_host

// ==== bench/asscu_props.sv ====
// link checker for the host-to-sensor spi connection
`timescale 1ns/10ps
module asscu_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic storeBusyOut,
  input wire logic errOut
);
  logic        sclkQ;
  logic [4:0]  bitCnt;
  logic [14:0] shift;
  logic [5:0]  gapCnt;
  logic        lastRise;
  logic [2:0]  cmd;

  // sixteenth rising link clock of a frame, command bits already shifted in
  assign lastRise = sclk & ~sclkQ & ~csN & (bitCnt == 5'h0f);
  assign cmd      = shift[14:12];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) sclkQ <= 1'b0;
    else sclkQ <= sclk;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitCnt <= 5'h00;
      shift  <= 15'h0000;
    end else if (csN) begin
      bitCnt <= 5'h00;
    end else if (sclk && !sclkQ) begin
      bitCnt <= bitCnt + 5'h01;
      shift  <= {shift[13:0], mosi};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) gapCnt <= 6'h3f;
    else if (!csN) gapCnt <= 6'h00;
    else if (gapCnt != 6'h3f) gapCnt <= gapCnt + 6'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_START_BUSY: assert property ($fell(sys_rst) |-> storeBusyOut [*8]
    ##[1:40] !storeBusyOut)
    else $error("start-up busy window wrong");
  AST_BUSY_HOLD: assert property ($rose(storeBusyOut) |-> storeBusyOut [*8])
    else $error("busy dropped too early");
  AST_STORE_BUSY: assert property (lastRise && cmd[2] && cmd != 3'h4
    && !storeBusyOut |-> ##[1:30] storeBusyOut)
    else $error("store or restore did not raise busy");
  AST_CLEAR: assert property (lastRise && cmd == 3'h1 |-> ##[1:30] !errOut)
    else $error("error pin not cleared");
  AST_PARITY: assert property (lastRise && cmd == 3'h3 |-> ##[1:30] errOut)
    else $error("bad code left error pin low");
  AST_SCLK_IDLE: assert property (csN |-> !sclk)
    else $error("link clock running outside frame");
  AST_FRAME_LEN: assert property ($rose(csN) |-> bitCnt == 5'h10)
    else $error("frame not sixteen clocks");
  AST_GAP: assert property ($fell(csN) |-> gapCnt >= 6'h32)
    else $error("frame gap too short");
  AST_MISO_EDGE: assert property (!csN && !$past(csN) && $changed(miso) |-> $rose(sclk))
    else $error("miso moved off rising edge");

  cover property (lastRise && cmd == 3'h6);
  cover property ($rose(errOut));
  cover property ($fell(storeBusyOut));
endmodule // asscu_props

// ==== bench/angle_sensor_spi_command_unit_tb.sv ====
// testbench: host and sensor ends joined, plus a sensor end driven directly
`timescale 1ns/10ps
module angle_sensor_spi_command_unit_tb;
  logic        core_clk;
  logic        sys_rst;
  logic [15:0] angle;
  logic [15:0] angle2;
  logic        cmdValid;
  logic [2:0]  cmdCode;
  logic [4:0]  cmdAddr;
  logic [7:0]  cmdValue;
  logic        cmdReady, respValid, ackMismatch, errSeen;
  logic [15:0] respWord;
  logic        parFault, spFault, parFault2, spFault2;
  logic [15:0] rx;
  int          err_total;
  int          total_checks;

  asscu_link_if lnk ();
  asscu_link_if lnk2 ();

  asscu_device #(.BUSY_CYCLES(20)) u_asscu_device (
    .core_clk(core_clk), .sys_rst(sys_rst), .angle(angle),
    .frameParityFault(parFault), .commandSpacingFault(spFault), .link(lnk));
  // start-up busy kept long so the directly driven end can be hit while busy
  asscu_device #(.BUSY_CYCLES(2000)) u_asscu_device_2 (
    .core_clk(core_clk), .sys_rst(sys_rst), .angle(angle2),
    .frameParityFault(parFault2), .commandSpacingFault(spFault2), .link(lnk2));
  asscu_host u_asscu_host (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdAddr(cmdAddr), .cmdValue(cmdValue), .cmdReady(cmdReady), .respValid(respValid),
    .respWord(respWord), .ackMismatch(ackMismatch), .errSeen(errSeen), .link(lnk));
  asscu_props u_asscu_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .sclk(lnk.sclk), .csN(lnk.csN),
    .mosi(lnk.mosi), .miso(lnk.miso), .storeBusyOut(lnk.storeBusyOut),
    .errOut(lnk.errOut));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic finish_test;
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // kind 0: full angle back, 1: angle high byte and lo, 2: answer not checked
  task automatic op(input logic [2:0] c, input logic [4:0] a, input logic [7:0] v,
                    input int kind, input logic [7:0] lo);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 9000) begin
      @(posedge core_clk);
      #1 n++;
    end
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdCode  <= c;
    cmdAddr  <= a;
    cmdValue <= v;
    angle    <= angle + 16'h1f3b;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (respValid !== 1'b1 && n < 9000);
    if (n >= 9000) err_total++;
    if (kind == 0) chk(respWord, angle);
    else if (kind == 1) chk(respWord, {angle[15:8], lo});
  endtask

  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    lnk2.csN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      lnk2.mosi <= w[i];
      #40 lnk2.sclk <= 1'b1;
      #40 lnk2.sclk <= 1'b0;
      r[i] = lnk2.miso;
    end
    #40 lnk2.csN <= 1'b1;
    lnk2.mosi <= ~w[0];
    #240;
  endtask

  task automatic wait2;
    int n;
    n = 0;
    while (lnk2.storeBusyOut !== 1'b0 && n < 3000) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk({15'h0000, lnk2.storeBusyOut}, 16'h0000);
  endtask

  initial begin
    // the host branch needs about 13000 cycles, the directly driven branch about 6000
    repeat (40000) @(posedge core_clk);
    err_total++;
    finish_test();
  end

  initial begin
    angle = 16'h3c5a;
    angle2 = 16'h9e17;
    cmdValid = 1'b0;
    cmdCode = 3'h0;
    cmdAddr = 5'h00;
    cmdValue = 8'h00;
    lnk2.sclk = 1'b0;
    lnk2.csN = 1'b1;
    lnk2.mosi = 1'b0;
    err_total = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1 chk({15'h0000, lnk.storeBusyOut}, 16'h0001);
    fork
      begin
        op(3'h2, 5'h04, 8'h00, 1, asscu_pkg::FACTORY[4]);
        op(3'h4, 5'h09, 8'h80, 1, 8'h80);
        chk({15'h0000, ackMismatch}, 16'h0000);
        op(3'h7, 5'h09, 8'h00, 0, 8'h00);
        op(3'h4, 5'h09, 8'h00, 1, 8'h00);
        op(3'h5, 5'h00, 8'h00, 0, 8'h00);
        op(3'h2, 5'h09, 8'h00, 1, 8'h80);
        op(3'h4, 5'h04, 8'h11, 1, 8'h11);
        op(3'h6, 5'h00, 8'h00, 0, 8'h00);
        op(3'h4, 5'h04, 8'h22, 1, 8'h22);
        op(3'h5, 5'h00, 8'h00, 0, 8'h00);
        op(3'h2, 5'h04, 8'h00, 1, 8'h11);
        op(3'h0, 5'h00, 8'h00, 0, 8'h00);
        op(3'h3, 5'h00, 8'h00, 2, 8'h00);
        chk({14'h0000, errSeen, parFault}, 16'h0003);
        op(3'h2, 5'h1a, 8'h00, 1, 8'h08);
        op(3'h4, 5'h1a, 8'hff, 1, 8'h08);
        chk({15'h0000, ackMismatch}, 16'h0001);
        op(3'h1, 5'h00, 8'h00, 0, 8'h00);
        chk({12'h000, spFault, errSeen, parFault, lnk.errOut}, 16'h0000);
        op(3'h2, 5'h1a, 8'h00, 1, 8'h00);
      end
      begin
        #13;
        xfer(16'h84a5, rx);
        xfer(16'hc000, rx);
        chk(rx, {angle2[15:8], 8'ha5});
        xfer(16'h0000, rx);
        chk(rx, angle2);
        chk({14'h0000, spFault2, lnk2.errOut}, 16'h0003);
        chk({15'h0000, lnk2.storeBusyOut}, 16'h0001);
        wait2();
        xfer(16'ha000, rx);
        xfer(16'h0000, rx);
        chk(rx, angle2);
        chk({15'h0000, lnk2.storeBusyOut}, 16'h0001);
        wait2();
        xfer(16'h4400, rx);
        xfer(16'h0000, rx);
        chk(rx, {angle2[15:8], asscu_pkg::FACTORY[4]});
        xfer(16'h2000, rx);
        xfer(16'h0000, rx);
        chk(rx, angle2);
        chk({13'h0000, spFault2, parFault2, lnk2.errOut}, 16'h0000);
      end
    join
    finish_test();
  end
endmodule // angle_sensor_spi_command_unit_tb
